// file: hw/hpg_params.svh
`ifndef HPG_PARAMS_SVH
`define HPG_PARAMS_SVH

// Register page and addresses
`define HPG_PAGE_F 4'hF
`define HPG_ADDR_P4_DRIVE 8'h9C
`define HPG_ADDR_P5_DRIVE 8'h9D
`define HPG_ADDR_P6_DRIVE 8'h9E
`define HPG_ADDR_P7_DRIVE 8'h9F
`define HPG_ADDR_P4_LATCH 8'hC8
`define HPG_ADDR_P5_LATCH 8'hD8
`define HPG_ADDR_P6_LATCH 8'hE8
`define HPG_ADDR_P7_LATCH 8'hF8
`define HPG_BIT_BASE_MASK 8'hF8

// Reset values
`define HPG_RST_LATCH 8'hFF
`define HPG_RST_DRIVE 8'h00

// Port 4 strobe pin positions
`define HPG_P4_WR_BIT 7
`define HPG_P4_RD_BIT 6
`define HPG_P4_ALE_BIT 5

`endif

// file: hw/hpg_pkg.sv
package hpg_pkg;

    typedef logic [3:0][7:0] hpg_ports_t;

    // Memory interface request toward the high ports
    typedef struct packed {
        logic active;
        logic mux_mode;
        logic wr_n;
        logic rd_n;
        logic ale;
        logic data_oe;
        logic [15:0] addr;
        logic [7:0] wdata;
    } hpg_external_memory_interface_t;

    // Per-port pin cell control
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] drive_type;
        logic [7:0] ovr_en;
        logic [7:0] ovr_val;
        logic [7:0] force_od;
        logic [7:0] hiz;
        logic pu_disable;
    } hpg_cell_t;

endpackage : hpg_pkg

// file: hw/hpg_pin_cell.sv
`timescale 1ns/1ns
`include "hpg_params.svh"

module hpg_pin_cell
    import hpg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire hpg_cell_t ctl,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pullup_en
);

    initial begin
        if (WIDTH != 8) $error("hpg_pin_cell serves byte-wide ports only");
    end

    logic [WIDTH-1:0] next_out;
    logic [WIDTH-1:0] next_oe;
    logic [WIDTH-1:0] next_pu;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            // Memory interface wins over the latch while it owns a pin
            next_out[i] = ctl.ovr_en[i] ? ctl.ovr_val[i] : ctl.latch[i];
            // Low driven unless hiz; high only in push-pull
            next_oe[i] = !next_out[i] ||
                (ctl.drive_type[i] && !ctl.force_od[i]);
            if (ctl.hiz[i]) begin
                next_oe[i] = 1'b0;
            end
            // Pullup off when disabled or pin pulls itself low
            next_pu[i] = !ctl.pu_disable &&
                !(next_oe[i] && !next_out[i]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_out <= '1;
            pin_oe <= '0;
            pullup_en <= '1;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            pullup_en <= next_pu;
        end
    end

endmodule : hpg_pin_cell

// file: hw/hpg_top.sv
`timescale 1ns/1ns
`include "hpg_params.svh"

module hpg_top
    import hpg_pkg::*;
#(
    parameter int PORTS = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    input wire logic sfr_bit_wr,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_val,
    input wire logic weak_pullup_disable,
    input wire logic [31:0] od_force,
    input wire hpg_external_memory_interface_t external_memory_interface,
    input wire logic [31:0] pin_in,
    output logic [7:0] sfr_rdata,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pullup_en
);

    initial begin
        if (PORTS != 4) $error("hpg_top is built for exactly four ports");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Returns {hit, is_latch, port index}
    function automatic logic [3:0] decode(input logic [7:0] a);
        case (a)
            `HPG_ADDR_P4_LATCH: decode = 4'hC;
            `HPG_ADDR_P5_LATCH: decode = 4'hD;
            `HPG_ADDR_P6_LATCH: decode = 4'hE;
            `HPG_ADDR_P7_LATCH: decode = 4'hF;
            `HPG_ADDR_P4_DRIVE: decode = 4'h8;
            `HPG_ADDR_P5_DRIVE: decode = 4'h9;
            `HPG_ADDR_P6_DRIVE: decode = 4'hA;
            `HPG_ADDR_P7_DRIVE: decode = 4'hB;
            default: decode = 4'h0;
        endcase
    endfunction : decode

    logic page_ok;
    logic [3:0] dec;
    logic [3:0] bit_dec;
    assign page_ok = (sfr_page == `HPG_PAGE_F);
    assign dec = decode(sfr_addr);
    assign bit_dec = decode(sfr_bit_addr & `HPG_BIT_BASE_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    logic [31:0] pin_s1;
    logic [31:0] pin_s2;
    logic [31:0] pin_s3;
    hpg_ports_t pin_state;
    hpg_ports_t next_pin_state;

    always_comb begin
        // Accept a level only when stages two and three agree
        next_pin_state = pin_state;
        for (int i = 0; i < 32; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
                next_pin_state[i/8][i%8] = pin_s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
            pin_state <= '1;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_state <= next_pin_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file

    hpg_ports_t latch;
    hpg_ports_t drive_type;
    hpg_ports_t next_latch;
    hpg_ports_t next_drive_type;
    logic [7:0] next_rdata;

    always_comb begin
        next_latch = latch;
        next_drive_type = drive_type;
        next_rdata = sfr_rdata;
        if (sfr_wr && page_ok && dec[3]) begin
            if (dec[2]) begin
                next_latch[dec[1:0]] = sfr_wdata;
            end else begin
                next_drive_type[dec[1:0]] = sfr_wdata;
            end
        end
        // Bit write touches one latch bit only
        if (sfr_bit_wr && page_ok && bit_dec[3] && bit_dec[2]) begin
            next_latch[bit_dec[1:0]][sfr_bit_addr[2:0]] = sfr_bit_val;
        end
        if (sfr_rd) begin
            next_rdata = 8'h00;
            if (page_ok && dec[3]) begin
                if (!dec[2]) begin
                    next_rdata = drive_type[dec[1:0]];
                end else if (sfr_rmw) begin
                    next_rdata = latch[dec[1:0]];
                end else begin
                    next_rdata = pin_state[dec[1:0]];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            latch <= {4{`HPG_RST_LATCH}};
            drive_type <= {4{`HPG_RST_DRIVE}};
            sfr_rdata <= 8'h00;
        end else begin
            latch <= next_latch;
            drive_type <= next_drive_type;
            sfr_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory interface pin ownership

    hpg_ports_t ovr_en;
    hpg_ports_t ovr_val;
    hpg_ports_t hiz;

    always_comb begin
        ovr_en = '0;
        ovr_val = '0;
        hiz = '0;
        if (external_memory_interface.active) begin
            ovr_en[0][`HPG_P4_WR_BIT] = 1'b1;
            ovr_en[0][`HPG_P4_RD_BIT] = 1'b1;
            ovr_en[0][`HPG_P4_ALE_BIT] = 1'b1;
            ovr_val[0][`HPG_P4_WR_BIT] = external_memory_interface.wr_n;
            ovr_val[0][`HPG_P4_RD_BIT] = external_memory_interface.rd_n;
            ovr_val[0][`HPG_P4_ALE_BIT] = external_memory_interface.ale;
            // Port 5 idles to its latch in multiplexed mode
            ovr_en[1] = {8{!external_memory_interface.mux_mode}};
            ovr_val[1] = external_memory_interface.addr[15:8];
            ovr_en[2] = 8'hFF;
            ovr_val[2] = external_memory_interface.mux_mode ? external_memory_interface.addr[15:8] : external_memory_interface.addr[7:0];
            ovr_en[3] = 8'hFF;
            if (external_memory_interface.mux_mode && external_memory_interface.ale) begin
                ovr_val[3] = external_memory_interface.addr[7:0];
            end else begin
                ovr_val[3] = external_memory_interface.wdata;
                // Reads release the data bus so the memory can drive it
                hiz[3] = {8{!external_memory_interface.data_oe}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers

    for (genvar p = 0; p < 4; p++) begin : g_port
        hpg_cell_t ctl;
        assign ctl = '{latch: latch[p], drive_type: drive_type[p],
            ovr_en: ovr_en[p], ovr_val: ovr_val[p],
            force_od: od_force[p*8 +: 8], hiz: hiz[p],
            pu_disable: weak_pullup_disable};
        hpg_pin_cell #(.WIDTH(8)) u_cell (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ctl(ctl),
            .pin_out(pin_out[p*8 +: 8]),
            .pin_oe(pin_oe[p*8 +: 8]),
            .pullup_en(pullup_en[p*8 +: 8])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_byte_write: assert property (
        sfr_wr && page_ok && sfr_addr == `HPG_ADDR_P4_LATCH && !sfr_bit_wr
        |=> latch[0] == $past(sfr_wdata))
        else $error("port 4 latch missed a byte write");

    chk_page_gate: assert property (
        sfr_wr && !page_ok && !sfr_bit_wr |=> $stable(latch))
        else $error("write off page F changed a latch");

    chk_pin_read: assert property (
        sfr_rd && page_ok && !sfr_rmw && sfr_addr == `HPG_ADDR_P5_LATCH
        |=> sfr_rdata == $past(pin_state[1]))
        else $error("port read did not return pin levels");

    chk_rmw_read: assert property (
        sfr_rd && page_ok && sfr_rmw && sfr_addr == `HPG_ADDR_P6_LATCH
        |=> sfr_rdata == $past(latch[2]))
        else $error("read-modify-write did not return latch");

    chk_drive_low: assert property (
        !external_memory_interface.active && !latch[0][0] |=> pin_oe[0] && !pin_out[0])
        else $error("latch 0 did not drive pin low");

    chk_open_drain: assert property (
        !external_memory_interface.active && latch[0][1] && !drive_type[0][1] |=> !pin_oe[1])
        else $error("open-drain high was driven");

    chk_push_pull: assert property (
        !external_memory_interface.active && latch[1][0] && drive_type[1][0] && !od_force[8]
        |=> pin_oe[8] && pin_out[8])
        else $error("push-pull high not driven");

    chk_force_od: assert property (
        od_force[16] |=> !(pin_oe[16] && pin_out[16]))
        else $error("forced open-drain pin driven high");

    chk_external_memory_interface_strobe: assert property (
        external_memory_interface.active |=> pin_out[7] == $past(external_memory_interface.wr_n)
            && pin_out[6] == $past(external_memory_interface.rd_n))
        else $error("strobes not on port 4");

    chk_external_memory_interface_addr: assert property (
        external_memory_interface.active && !external_memory_interface.mux_mode |=> pin_out[15:8] ==
            $past(external_memory_interface.addr[15:8]) && pin_out[23:16] == $past(external_memory_interface.addr[7:0]))
        else $error("address bytes not on ports 5 and 6");

    chk_read_hiz: assert property (
        external_memory_interface.active && !external_memory_interface.ale && !external_memory_interface.data_oe |=> pin_oe[31:24] == 8'h00)
        else $error("data bus driven during read");

    chk_bit_write: assert property (
        sfr_bit_wr && page_ok && !sfr_wr
            && sfr_bit_addr == (`HPG_ADDR_P7_LATCH | 8'h07)
        |=> latch[3][7] == $past(sfr_bit_val)
            && latch[3][6:0] == $past(latch[3][6:0]))
        else $error("bit write disturbed other bits");

    chk_pullup_low: assert property (
        pin_oe[0] && !pin_out[0] |-> !pullup_en[0])
        else $error("pullup on while pin drives low");

    cov_bit_write: cover property (sfr_bit_wr && page_ok && bit_dec[3]);
    cov_external_memory_interface_mux: cover property (external_memory_interface.active && external_memory_interface.mux_mode ##1 external_memory_interface.ale);
    cov_rmw: cover property (sfr_rd && sfr_rmw && page_ok && dec[2]);

endmodule : hpg_top

// file: testbench/hpg_board.sv
`timescale 1ns/1ns

module hpg_board (
    input wire logic clk_sys,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pullup_en,
    input wire logic [31:0] ext_drv,
    input wire logic [31:0] ext_val,
    output logic [31:0] pin_in
);
    logic flip = 1'h0;

    always @(posedge clk_sys) begin
        flip <= ~flip;
    end

    // Floating lines wander so no stale level passes for a match
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_drv[i])
                pin_in[i] = ext_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'h1;
            else
                pin_in[i] = flip ^ i[0];
        end
    end
endmodule : hpg_board

// file: testbench/test_hpg_top.sv
`timescale 1ns/1ns
`include "hpg_params.svh"

module test_hpg_top;
    import hpg_pkg::*;
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] sfr_page = 4'h0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'h0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'h0;
    logic sfr_rmw = 1'h0;
    logic sfr_bit_wr = 1'h0;
    logic [7:0] sfr_bit_addr = 8'h00;
    logic sfr_bit_val = 1'h0;
    logic weak_pullup_disable = 1'h0;
    logic [31:0] od_force = 32'h0;
    hpg_external_memory_interface_t external_memory_interface = '0;
    logic [31:0] ext_drv = 32'h0;
    logic [31:0] ext_val = 32'h0;
    logic [31:0] pin_in, pin_out, pin_oe, pullup_en, m_lat, m_dt;
    logic [7:0] sfr_rdata, q;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 79;

    always #50 clk_sys = ~clk_sys;

    hpg_top #(.PORTS(4)) DUT (.clk_sys(clk_sys), .nrst(nrst),
        .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
        .sfr_bit_val(sfr_bit_val), .weak_pullup_disable(weak_pullup_disable),
        .od_force(od_force), .external_memory_interface(external_memory_interface), .pin_in(pin_in),
        .sfr_rdata(sfr_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en));

    hpg_board board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_drv(ext_drv), .ext_val(ext_val),
        .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Pins settle two edges after the strobe, so the task waits them out
    task automatic wr(input logic [3:0] pg, input logic [7:0] a, d);
        @(negedge clk_sys);
        sfr_page = pg;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        @(negedge clk_sys);
        sfr_wr = 1'h0;
        @(negedge clk_sys);
    endtask : wr

    task automatic rd(input logic [3:0] pg, input logic [7:0] a,
            input logic rmw, output logic [7:0] r);
        @(negedge clk_sys);
        sfr_page = pg;
        sfr_addr = a;
        sfr_rmw = rmw;
        sfr_rd = 1'h1;
        @(negedge clk_sys);
        sfr_rd = 1'h0;
        sfr_rmw = 1'h0;
        r = sfr_rdata;
    endtask : rd

    task automatic bwr(input logic [7:0] a, input logic v);
        @(negedge clk_sys);
        sfr_page = `HPG_PAGE_F;
        sfr_bit_addr = a;
        sfr_bit_val = v;
        sfr_bit_wr = 1'h1;
        @(negedge clk_sys);
        sfr_bit_wr = 1'h0;
        @(negedge clk_sys);
    endtask : bwr

    function automatic logic [31:0] exp_pu(logic [31:0] o, e, logic w);
        return {32{~w}} & ~(e & ~o);
    endfunction : exp_pu

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clk_sys);
        nrst = 1'h1;
        chk(pin_oe, 32'h0, "reset oe");
        chk(pin_out, 32'hFFFFFFFF, "reset out");
        chk(pullup_en, 32'hFFFFFFFF, "reset pullup");
        for (int p = 0; p < 4; p++) begin
            rd(`HPG_PAGE_F, `HPG_ADDR_P4_DRIVE + p, 1'h0, q);
            chk(q, 8'h00, "drive reset");
        end
        $display("test reset done");
        // Corner first: all low and push-pull, then random mixes
        for (int k = 0; k < 6; k++) begin
            for (int p = 0; p < 4; p++) begin
                m_dt[8*p+:8] = (k == 0) ? 8'hFF : 8'($random(seed));
                m_lat[8*p+:8] = (k == 0) ? 8'h00 : 8'($random(seed));
                wr(`HPG_PAGE_F, `HPG_ADDR_P4_DRIVE + p, m_dt[8*p+:8]);
                wr(`HPG_PAGE_F, `HPG_ADDR_P4_LATCH + 8'(16*p), m_lat[8*p+:8]);
            end
            od_force = (k < 2) ? 32'h0 : $random(seed);
            weak_pullup_disable = k[0];
            @(negedge clk_sys);
            chk(pin_out, m_lat, "latch out");
            chk(pin_oe, ~m_lat | (m_dt & ~od_force), "oe");
            chk(pullup_en, exp_pu(m_lat, ~m_lat | (m_dt & ~od_force), k[0]),
                "pullup");
        end
        $display("test drive modes done");
        od_force = 32'h0;
        weak_pullup_disable = 1'h0;
        m_lat = 32'hFFFFFFFF;
        for (int p = 0; p < 4; p++) begin
            wr(`HPG_PAGE_F, `HPG_ADDR_P4_DRIVE + p, 8'h00);
            wr(`HPG_PAGE_F, `HPG_ADDR_P4_LATCH + 8'(16*p), 8'hFF);
        end
        ext_val = $random(seed) & 32'h7F7F7F7F;
        ext_drv = 32'hFFFFFFFF;
        repeat (5) @(negedge clk_sys);
        for (int p = 0; p < 4; p++) begin
            rd(`HPG_PAGE_F, `HPG_ADDR_P4_LATCH + 8'(16*p), 1'h0, q);
            chk(q, ext_val[8*p+:8], "pin read");
            rd(`HPG_PAGE_F, `HPG_ADDR_P4_LATCH + 8'(16*p), 1'h1, q);
            chk(q, 8'hFF, "rmw read");
        end
        ext_drv = 32'h0;
        $display("test reads done");
        wr(4'h0, `HPG_ADDR_P4_LATCH, 8'h00);
        chk(pin_out, m_lat, "off page write");
        rd(4'h0, `HPG_ADDR_P4_DRIVE, 1'h0, q);
        chk(q, 8'h00, "off page read");
        rd(`HPG_PAGE_F, 8'hA0, 1'h0, q);
        chk(q, 8'h00, "unmapped read");
        bwr(`HPG_ADDR_P4_LATCH | 8'h03, 1'h0);
        bwr(`HPG_ADDR_P7_LATCH | 8'h07, 1'h0);
        m_lat = 32'h7FFFFFF7;
        chk(pin_out, m_lat, "bit write");
        $display("test refusals and bits done");
        for (int p = 0; p < 4; p++)
            wr(`HPG_PAGE_F, `HPG_ADDR_P4_DRIVE + p, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            @(negedge clk_sys);
            external_memory_interface.active = 1'h1;
            external_memory_interface.mux_mode = (k != 0);
            external_memory_interface.ale = (k == 1);
            external_memory_interface.data_oe = (k != 2);
            {external_memory_interface.wr_n, external_memory_interface.rd_n} = 2'($random(seed));
            external_memory_interface.addr = 16'($random(seed));
            external_memory_interface.wdata = 8'($random(seed));
            @(negedge clk_sys);
            chk(pin_out[7:5], {external_memory_interface.wr_n, external_memory_interface.rd_n, external_memory_interface.ale}, "strobes");
            chk(pin_out[15:8], k ? m_lat[15:8] : external_memory_interface.addr[15:8], "p5");
            chk(pin_out[23:16], k ? external_memory_interface.addr[15:8] : external_memory_interface.addr[7:0], "p6");
            if (k != 2)
                chk(pin_out[31:24], k ? external_memory_interface.addr[7:0] : external_memory_interface.wdata, "p7");
            else
                chk(pin_oe[31:24], 8'h00, "read releases data");
        end
        external_memory_interface = '0;
        @(negedge clk_sys);
        chk(pin_out, m_lat, "memory move ends");
        $display("test memory interface done");
        close_out();
    end
endmodule : test_hpg_top
